// ---- inc/ccp_pkg.sv ----
package ccp_pkg;
  // register offsets on the core i/o bus
  localparam logic [5:0]  KEY_OFS      = 6'h04;  // config_change_key
  localparam logic [5:0]  SPL_OFS      = 6'h0D;  // stack_pointer_low
  localparam logic [5:0]  SPH_OFS      = 6'h0E;  // stack_pointer_high
  localparam logic [5:0]  FLAGS_OFS    = 6'h0F;  // status_flags
  localparam logic [5:0]  HIGH_STEP    = 6'h01;  // high byte sits one above low
  // key signatures
  localparam logic [7:0]  SELF_PROGRAM_SIGNATURE = 8'h9D;
  localparam logic [7:0]  IO_UNLOCK_SIGNATURE    = 8'hD8;
  // window length in executed instructions
  localparam logic [2:0]  WIN_INSTR    = 3'h4;
  // stack pointer: implemented bits and reset value (top of sram)
  localparam logic [15:0] SP_MASK      = 16'h3FFF;
  localparam logic [15:0] SP_RESET     = 16'h3FFF;
  // status_flags bit positions
  localparam int FLAG_I = 7;
  localparam int FLAG_T = 6;
  localparam int FLAG_H = 5;
  localparam int FLAG_S = 4;
  localparam int FLAG_V = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  // controller registers on axi4-lite (byte addresses)
  localparam logic [3:0]  CMD_ADDR     = 4'h0;
  localparam logic [3:0]  STAT_ADDR    = 4'h4;
  localparam logic [3:0]  EVT_ADDR     = 4'h8;
  // command word fields
  localparam int CMD_DLO   = 0;   // [7:0] low data
  localparam int CMD_DHI   = 8;   // [15:8] high data
  localparam int CMD_ADR   = 16;  // [21:16] i/o offset
  localparam int CMD_WR    = 22;  // 1 write, 0 read
  localparam int CMD_WIDE  = 23;  // sixteen-bit pair access
  localparam int CMD_UNL   = 24;  // [25:24] 0 none, 1 io, 2 self-program
  // event word fields
  localparam int EVT_INSTR = 0;
  localparam int EVT_DMEM  = 1;
  localparam int EVT_NVM   = 2;
  localparam int EVT_SLEEP = 3;
  localparam int EVT_SEI   = 4;
  localparam int EVT_CLI   = 5;
  localparam int EVT_BST   = 6;
  localparam int EVT_BSTV  = 7;
  localparam int EVT_ALU   = 8;
  localparam int EVT_AFL   = 9;   // [13:9] h v n z c
  localparam int EVT_IRQ   = 14;
  // status word fields
  localparam int ST_BUSY   = 16;
  localparam int ST_IRQEN  = 17;
  localparam int ST_IOWIN  = 18;
  localparam int ST_SPMWIN = 19;
  localparam int ST_PEND   = 20;
  localparam int ST_TFLAG  = 21;
  localparam int ST_TAKEN  = 24;  // [31:24] interrupts taken
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  UNL_IO       = 2'h1;
  localparam logic [1:0]  UNL_SPM      = 2'h2;
endpackage

// ---- inc/ccp_io_if.sv ----
`timescale 1ns/1ps
interface ccp_io_if;
  logic [5:0] ioAddr;      // i/o offset
  logic [7:0] ioWdata;     // write data
  logic       ioWr;        // i/o write strobe
  logic       ioRd;        // i/o read strobe
  logic [7:0] ioRdata;     // read data, one cycle after ioRd
  logic       ioWait;      // one-cycle wait state
  logic       instrDone;   // an instruction retired
  logic       dataMemWr;   // data memory write
  logic       nvmAccess;   // flash / nvm controller / eeprom access
  logic       sleepExec;   // sleep instruction
  logic       seiExec;     // irq_enable_instr
  logic       cliExec;     // irq_disable_instr
  logic       bstExec;     // bit_store_instr
  logic       bstValue;    // bit stored
  logic       aluUpdate;   // alu result flags valid
  logic [4:0] aluFlags;    // h v n z c
  logic       tFlag;       // source for bit_load_instr
  logic       irqEnable;   // interrupts may be taken
  logic       ioUnlock;    // protected i/o write allowed
  logic       spmUnlock;   // nvm command write allowed
  modport device (input ioAddr, ioWdata, ioWr, ioRd, instrDone, dataMemWr, nvmAccess,
                  sleepExec, seiExec, cliExec, bstExec, bstValue, aluUpdate, aluFlags,
                  output ioRdata, ioWait, tFlag, irqEnable, ioUnlock, spmUnlock);
  modport cpu (output ioAddr, ioWdata, ioWr, ioRd, instrDone, dataMemWr, nvmAccess,
               sleepExec, seiExec, cliExec, bstExec, bstValue, aluUpdate, aluFlags,
               input ioRdata, ioWait, tFlag, irqEnable, ioUnlock, spmUnlock);
endinterface

// ---- hdl/ccp_instr_window.sv ----
`timescale 1ns/1ps
module ccp_instr_window
  import ccp_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // control
  input  wire logic load,        // arm for WIN_INSTR instructions
  input  wire logic cancel,      // disarm at once
  input  wire logic tick,        // one instruction executed
  // state
  output logic      active,      // registered window state
  output logic      activeNext   // state taking effect next edge
);
  typedef struct packed {
    logic [2:0] count;  // instructions left
    logic       act;    // window open
  } ccp_win_s;

  ccp_win_s win_q, win_d;

  // load beats cancel so that an arming write also closing the old window rearms
  always_comb begin
    win_d = win_q;
    if (load) begin
      win_d.count = WIN_INSTR;
    end else if (cancel) begin
      win_d.count = 3'h0;
    end else if (tick && win_q.count != 3'h0) begin
      win_d.count = win_q.count - 3'h1;
    end
    win_d.act = (win_d.count != 3'h0);
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      win_q <= '0;
    end else begin
      win_q <= win_d;
    end
  end

  assign active     = win_q.act;
  assign activeNext = win_d.act;
endmodule // ccp_instr_window

// ---- hdl/ccp_core_regs.sv ----
`timescale 1ns/1ps
// What this block does
// - 0x9D arms self-program, 0xD8 arms io
// - protected io write only within four instructions
// - software sets change-enable bit with data; no such bit exists in this block
// - io window closes on writes, nvm, sleep
// - nvm command write only within four instructions
// - self-program window closes on nvm, sleep
// - no interrupt taken while window armed
// - pending interrupts resume after window ends
// - key bit0 io window, bit1 self-program
// - key bits seven to two read zero
// - stack pointer resets to sram top
// - only needed stack bits; others read zero
// - stack low at base, high at +1
// - low write blocks irq four instructions
// - flag bit 7 is global irq enable
// - taking interrupt never clears enable bit
// - changing enable via io adds wait cycle
// - flag bit 6 is bit copy store
// - sign flag equals negative xor overflow
// - h v n z c hold alu results
// - pair write: low to temp, high commits
// - pair read: low latches high into temp
module ccp_core_regs
  import ccp_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // core side
  ccp_io_if.device  io
);
  import ccp_pkg::*;

  typedef struct packed {
    logic [15:0] sp;       // stack pointer
    logic [7:0]  temp;     // shared pair temp byte
    logic        fI;       // global irq enable
    logic        fT;       // bit copy storage
    logic        fH;       // half carry
    logic        fV;       // overflow
    logic        fN;       // negative
    logic        fZ;       // zero
    logic        fC;       // carry
    logic [7:0]  rdata;    // read answer
    logic        waitSt;   // wait state pulse
    logic        irqEn;    // interrupt gate
  } ccp_core_s;

  ccp_core_s st_q, st_d;

  // decoded accesses
  logic keyWr;       // write to config_change_key
  logic splWr;       // write to stack_pointer_low
  logic ioAct;       // io window open
  logic ioNext;      // io window next
  logic spmAct;      // self-program window open
  logic spmNext;     // self-program window next
  logic splNext;     // sp low write block next
  logic flagS;       // derived sign flag
  logic [7:0] flags; // status_flags image

  assign keyWr = io.ioWr && io.ioAddr == KEY_OFS;
  assign splWr = io.ioWr && io.ioAddr == SPL_OFS;

  // io unlock window: any other write, nvm access or sleep closes it
  ccp_instr_window u_io_win (
    .mclk       (mclk),
    .reset      (reset),
    .load       (keyWr && io.ioWdata == IO_UNLOCK_SIGNATURE),
    .cancel     (io.ioWr || io.dataMemWr || io.nvmAccess || io.sleepExec),
    .tick       (io.instrDone),
    .active     (ioAct),
    .activeNext (ioNext)
  );

  // self-program window: only nvm access, sleep or a key value other than either signature closes it
  ccp_instr_window u_spm_win (
    .mclk       (mclk),
    .reset      (reset),
    .load       (keyWr && io.ioWdata == SELF_PROGRAM_SIGNATURE),
    .cancel     ((keyWr && io.ioWdata != IO_UNLOCK_SIGNATURE) || io.nvmAccess
                 || io.sleepExec),
    .tick       (io.instrDone),
    .active     (spmAct),
    .activeNext (spmNext)
  );

  // stack low write holds off interrupts until four instructions or next io write
  ccp_instr_window u_spl_blk (
    .mclk       (mclk),
    .reset      (reset),
    .load       (splWr),
    .cancel     (io.ioWr),
    .tick       (io.instrDone),
    .active     (),
    .activeNext (splNext)
  );

  // sign is never stored, so it can never disagree with n and v
  assign flagS = st_q.fN ^ st_q.fV;
  always_comb begin
    flags         = 8'h00;
    flags[FLAG_I] = st_q.fI;
    flags[FLAG_T] = st_q.fT;
    flags[FLAG_H] = st_q.fH;
    flags[FLAG_S] = flagS;
    flags[FLAG_V] = st_q.fV;
    flags[FLAG_N] = st_q.fN;
    flags[FLAG_Z] = st_q.fZ;
    flags[FLAG_C] = st_q.fC;
  end

  // next-state logic for all registers
  always_comb begin
    st_d        = st_q;
    st_d.waitSt = 1'b0;
    // alu result flags
    if (io.aluUpdate) begin
      {st_d.fH, st_d.fV, st_d.fN, st_d.fZ, st_d.fC} = io.aluFlags;
    end
    // bit copy storage
    if (io.bstExec) begin
      st_d.fT = io.bstValue;
    end
    // dedicated enable instructions; clear given last word if both appear
    if (io.seiExec) begin
      st_d.fI = 1'b1;
    end
    if (io.cliExec) begin
      st_d.fI = 1'b0;
    end
    // i/o writes
    if (io.ioWr) begin
      case (io.ioAddr)
        SPL_OFS: begin
          st_d.temp = io.ioWdata;
        end
        SPH_OFS: begin
          st_d.sp = {io.ioWdata, st_q.temp} & SP_MASK;
        end
        FLAGS_OFS: begin
          st_d.fI = io.ioWdata[FLAG_I];
          st_d.fT = io.ioWdata[FLAG_T];
          st_d.fH = io.ioWdata[FLAG_H];
          st_d.fV = io.ioWdata[FLAG_V];
          st_d.fN = io.ioWdata[FLAG_N];
          st_d.fZ = io.ioWdata[FLAG_Z];
          st_d.fC = io.ioWdata[FLAG_C];
          // changing the enable costs one bus wait cycle
          st_d.waitSt = io.ioWdata[FLAG_I] != st_q.fI;
        end
        default: begin
          // key handled by window modules, others not ours
        end
      endcase
    end
    // i/o reads, answered the next cycle
    st_d.rdata = 8'h00;
    if (io.ioRd) begin
      case (io.ioAddr)
        KEY_OFS: begin
          st_d.rdata = {6'h00, spmAct, ioAct};
        end
        SPL_OFS: begin
          st_d.rdata = st_q.sp[7:0];
          st_d.temp  = st_q.sp[15:8];
        end
        SPH_OFS: begin
          st_d.rdata = st_q.temp;
        end
        FLAGS_OFS: begin
          st_d.rdata = flags;
        end
        default: begin
          st_d.rdata = 8'h00;  // unmapped reads zero
        end
      endcase
    end
    // taking an interrupt never touches fI; gate only holds requests off
    st_d.irqEn = st_d.fI && !ioNext && !spmNext && !splNext;
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q    <= '0;
      st_q.sp <= SP_RESET & SP_MASK;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign io.ioRdata   = st_q.rdata;
  assign io.ioWait    = st_q.waitSt;
  assign io.tFlag     = st_q.fT;
  assign io.irqEnable = st_q.irqEn;
  assign io.ioUnlock  = ioAct;
  assign io.spmUnlock = spmAct;
endmodule // ccp_core_regs

// ---- hdl/ccp_cpu_ctrl.sv ----
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ccp_cpu_ctrl
  import ccp_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // axi4-lite write address
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // core bus toward the registers
  ccp_io_if.cpu            io
);
  import ccp_pkg::*;

  typedef enum logic [1:0] {IDLE, ACC1, ACC2, FIN} ccp_seq_e;

  typedef struct packed {
    ccp_seq_e    seq;      // access sequencer
    logic [31:0] cmd;      // command held
    logic [15:0] rdWord;   // read result lo/hi
    logic [1:0]  cap;      // read byte due {high, any}
    logic        awHave;   // address captured
    logic        wHave;    // data captured
    logic [3:0]  awA;      // write address low bits
    logic [31:0] wD;       // write data
    logic [1:0]  bR;       // write response
    logic        bV;       // response valid
    logic [31:0] rD;       // read data
    logic        rV;       // read valid
    logic        pend;     // interrupt request pending
    logic [7:0]  taken;    // interrupts taken
    logic [5:0]  ioA;      // bus outputs
    logic [7:0]  ioD;
    logic        ioW;
    logic        ioR;
    logic        instr;
    logic [13:0] evt;      // event pulses
  } ccp_ctl_s;

  ccp_ctl_s s_q, s_d;
  logic     doWrite;  // both halves captured
  logic     busy;     // sequencer running
  logic [31:0] stat;  // status word

  assign busy    = s_q.seq != IDLE || s_q.cap[0] || io.ioWait;
  // writes wait while busy, which stalls the bus
  assign doWrite = s_q.awHave && s_q.wHave && !s_q.bV && !busy;

  always_comb begin
    stat                  = 32'h0000_0000;
    stat[15:0]            = s_q.rdWord;
    stat[ST_BUSY]         = busy;
    stat[ST_IRQEN]        = io.irqEnable;
    stat[ST_IOWIN]        = io.ioUnlock;
    stat[ST_SPMWIN]       = io.spmUnlock;
    stat[ST_PEND]         = s_q.pend;
    stat[ST_TFLAG]        = io.tFlag;
    stat[ST_TAKEN +: 8]   = s_q.taken;
  end

  // bus slave, sequencer and interrupt pending bit
  always_comb begin
    s_d       = s_q;
    s_d.ioW   = 1'b0;
    s_d.ioR   = 1'b0;
    s_d.instr = 1'b0;
    s_d.evt   = 14'h0000;
    // capture address and data in either order
    if (awvalid && !s_q.awHave) begin
      s_d.awHave = 1'b1;
      s_d.awA    = awaddr[3:0];
    end
    if (wvalid && !s_q.wHave) begin
      s_d.wHave = 1'b1;
      s_d.wD    = wdata;
    end
    if (bready && s_q.bV) begin
      s_d.bV = 1'b0;
    end
    // whole-word registers; byte strobes are not honoured
    if (doWrite) begin
      s_d.awHave = 1'b0;
      s_d.wHave  = 1'b0;
      s_d.bV     = 1'b1;
      s_d.bR     = RESP_OKAY;
      case (s_q.awA)
        CMD_ADDR: begin
          s_d.cmd = s_q.wD;
          s_d.seq = ACC1;
          // unlocking writes the signature as its own instruction first
          if (s_q.wD[CMD_UNL +: 2] != 2'h0) begin
            s_d.ioA   = KEY_OFS;
            s_d.ioD   = (s_q.wD[CMD_UNL +: 2] == UNL_SPM) ? SELF_PROGRAM_SIGNATURE
                        : IO_UNLOCK_SIGNATURE;
            s_d.ioW   = 1'b1;
            s_d.instr = 1'b1;
          end
        end
        EVT_ADDR: begin
          s_d.evt  = s_q.wD[13:0];
          s_d.pend = s_q.pend | s_q.wD[EVT_IRQ];
        end
        default: begin
          s_d.bR = RESP_SLVERR;
        end
      endcase
    end
    // read channel
    if (rready && s_q.rV) begin
      s_d.rV = 1'b0;
    end
    if (arvalid && !s_q.rV) begin
      s_d.rV = 1'b1;
      s_d.rD = (araddr[3:0] == STAT_ADDR) ? stat
               : (araddr[3:0] == CMD_ADDR) ? s_q.cmd : 32'h0000_0000;
    end
    // access sequencer: pair accesses low byte first
    case (s_q.seq)
      IDLE: begin
      end
      ACC1: begin
        // protected access follows the signature directly
        s_d.ioA   = s_q.cmd[CMD_ADR +: 6];
        s_d.ioD   = s_q.cmd[CMD_DLO +: 8];
        s_d.ioW   = s_q.cmd[CMD_WR];
        s_d.ioR   = !s_q.cmd[CMD_WR];
        s_d.instr = 1'b1;
        s_d.seq   = s_q.cmd[CMD_WIDE] ? ACC2 : FIN;
      end
      ACC2: begin
        s_d.ioA   = s_q.cmd[CMD_ADR +: 6] + HIGH_STEP;
        s_d.ioD   = s_q.cmd[CMD_DHI +: 8];
        s_d.ioW   = s_q.cmd[CMD_WR];
        s_d.ioR   = !s_q.cmd[CMD_WR];
        s_d.instr = 1'b1;
        s_d.seq   = FIN;
      end
      FIN: begin
        // a wait state keeps the sequencer one more cycle
        s_d.seq = io.ioWait ? FIN : IDLE;
      end
      default: begin
        s_d.seq = IDLE;
      end
    endcase
    // read byte lands the cycle after its strobe
    s_d.cap = {s_q.ioR && s_q.ioA != s_q.cmd[CMD_ADR +: 6], s_q.ioR};
    if (s_q.cap[0]) begin
      s_d.rdWord[8 * s_q.cap[1] +: 8] = io.ioRdata;
    end
    // take a pending request only when the gate allows; new request wins
    if (s_q.pend && io.irqEnable && !(doWrite && s_q.awA == EVT_ADDR
        && s_q.wD[EVT_IRQ])) begin
      s_d.pend  = 1'b0;
      s_d.taken = s_q.taken + 8'h01;
    end
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q     <= '0;
      s_q.seq <= IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs from flops; rresp is tied to okay and instrDone ors two flops
  assign awready      = !s_q.awHave;
  assign wready       = !s_q.wHave;
  assign bresp        = s_q.bR;
  assign bvalid       = s_q.bV;
  assign arready      = !s_q.rV;
  assign rdata        = s_q.rD;
  assign rresp        = RESP_OKAY;
  assign rvalid       = s_q.rV;
  assign io.ioAddr    = s_q.ioA;
  assign io.ioWdata   = s_q.ioD;
  assign io.ioWr      = s_q.ioW;
  assign io.ioRd      = s_q.ioR;
  assign io.instrDone = s_q.instr | s_q.evt[EVT_INSTR];
  assign io.dataMemWr = s_q.evt[EVT_DMEM];
  assign io.nvmAccess = s_q.evt[EVT_NVM];
  assign io.sleepExec = s_q.evt[EVT_SLEEP];
  assign io.seiExec   = s_q.evt[EVT_SEI];
  assign io.cliExec   = s_q.evt[EVT_CLI];
  assign io.bstExec   = s_q.evt[EVT_BST];
  assign io.bstValue  = s_q.evt[EVT_BSTV];
  assign io.aluUpdate = s_q.evt[EVT_ALU];
  assign io.aluFlags  = s_q.evt[EVT_AFL +: 5];
endmodule // ccp_cpu_ctrl

// ---- sim/ccp_io_properties.sv ----
`timescale 1ns/1ps
module ccp_io_properties
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // core bus, cpu side
  input wire logic [5:0] ioAddr,
  input wire logic [7:0] ioWdata,
  input wire logic       ioWr,
  input wire logic       ioRd,
  input wire logic       instrDone,
  input wire logic       dataMemWr,
  input wire logic       nvmAccess,
  input wire logic       sleepExec,
  input wire logic       bstExec,
  input wire logic       bstValue,
  // core bus, device side
  input wire logic [7:0] ioRdata,
  input wire logic       ioWait,
  input wire logic       tFlag,
  input wire logic       irqEnable,
  input wire logic       ioUnlock,
  input wire logic       spmUnlock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic       keyIo;     // io signature write on the bus
  logic       keySpm;    // self-program signature write
  logic [2:0] winCnt_q;  // instructions seen inside the io window
  assign keyIo  = ioWr && ioAddr == KEY_OFS && ioWdata == IO_UNLOCK_SIGNATURE;
  assign keySpm = ioWr && ioAddr == KEY_OFS && ioWdata == SELF_PROGRAM_SIGNATURE;
  // count restarts on a re-arm, else a fresh window would look overrun
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      winCnt_q <= 3'h0;
    end else if (!ioUnlock || keyIo) begin
      winCnt_q <= 3'h0;
    end else if (instrDone) begin
      winCnt_q <= winCnt_q + 3'h1;
    end
  end
  property p_io_arm;
    keyIo && !dataMemWr && !nvmAccess && !sleepExec |=> ioUnlock;
  endproperty
  a_io_arm: assert property (p_io_arm) else $error("io window not armed");
  property p_spm_arm;
    keySpm && !nvmAccess && !sleepExec |=> spmUnlock && !ioUnlock;
  endproperty
  a_spm_arm: assert property (p_spm_arm) else $error("spm window not armed");
  property p_io_len;
    ioUnlock |-> winCnt_q < 3'h4;
  endproperty
  a_io_len: assert property (p_io_len) else $error("io window too long");
  property p_io_close;
    ioUnlock && !keyIo && (dataMemWr || nvmAccess || sleepExec || ioWr) |=> !ioUnlock;
  endproperty
  a_io_close: assert property (p_io_close) else $error("io window not cancelled");
  property p_spm_close;
    spmUnlock && !keySpm && (nvmAccess || sleepExec) |=> !spmUnlock;
  endproperty
  a_spm_close: assert property (p_spm_close) else $error("spm window not cancelled");
  property p_no_irq;
    ioUnlock || spmUnlock |-> !irqEnable;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq open in window");
  property p_key_read;
    ioRd && ioAddr == KEY_OFS |=> ioRdata == {6'h00, $past(spmUnlock), $past(ioUnlock)};
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read wrong");
  property p_wait_cause;
    ioWait |-> $past(ioWr) && $past(ioAddr) == FLAGS_OFS;
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stray wait state");
  property p_tbit;
    bstExec && !ioWr |=> tFlag == $past(bstValue);
  endproperty
  a_tbit: assert property (p_tbit) else $error("bit store lost");
endmodule // ccp_io_properties

// ---- sim/cpu_config_change_protect_tb.sv ----
`timescale 1ns/1ps
module cpu_config_change_protect_tb;
  import ccp_pkg::*;
  logic        mclk, reset;                  // clock and reset
  logic [31:0] awaddr, wdata, araddr, rdata; // axi payloads
  logic [3:0]  wstrb;                        // byte strobes
  logic [1:0]  bresp, rresp;                 // responses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] stat;                         // last status word
  logic [1:0]  resp;                         // last write response
  int sp = 'h3FFF, tmp, th, fl, iw, sw, spb, rv, d, pd, tk; // reference model
  int mismatches, num_checks;
  int ev[3] = '{EVT_DMEM, EVT_NVM, EVT_SLEEP}; // window cancelling events
  ccp_io_if bus ();
  ccp_core_regs i_ccp_core_regs (.mclk(mclk), .reset(reset), .io(bus));
  ccp_cpu_ctrl i_ccp_cpu_ctrl (.mclk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .io(bus));
  ccp_io_properties i_ccp_io_properties (.mclk(mclk), .reset(reset), .ioAddr(bus.ioAddr),
    .ioWdata(bus.ioWdata), .ioWr(bus.ioWr), .ioRd(bus.ioRd), .instrDone(bus.instrDone),
    .dataMemWr(bus.dataMemWr), .nvmAccess(bus.nvmAccess), .sleepExec(bus.sleepExec),
    .bstExec(bus.bstExec), .bstValue(bus.bstValue), .ioRdata(bus.ioRdata),
    .ioWait(bus.ioWait), .tFlag(bus.tFlag), .irqEnable(bus.irqEnable),
    .ioUnlock(bus.ioUnlock), .spmUnlock(bus.spmUnlock));
  // free running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic complete_run;
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // every wait is bounded; running out counts as a mismatch
  task automatic tmo(inout int n);
    n++;
    if (n > 400) begin
      mismatches++;
      complete_run();
    end
  endtask
  // both halves offered together, each dropped once taken
  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    int n = 0;
    logic [2:0] ok; // ready seen before the edge
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk);
      {ok, resp} = {awready, wready, bvalid, bresp};
      @(posedge mclk);
      if (ok[2]) awvalid <= 1'b0;
      if (ok[1]) wvalid <= 1'b0;
      tmo(n);
    end while (ok[0] !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] v);
    int n = 0;
    logic [1:0] ok; // ready seen before the edge
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk);
      {ok, v} = {arready, rvalid, rdata};
      @(posedge mclk);
      if (ok[1]) arvalid <= 1'b0;
      tmo(n);
    end while (ok[0] !== 1'b1);
    rready <= 1'b0;
  endtask
  // one executed instruction in the model
  task automatic tick;
    if (iw > 0) iw--;
    if (sw > 0) sw--;
    if (spb > 0) spb--;
  endtask
  // one i/o access in the model; five since the key write ticks too
  task automatic acc(input logic [5:0] o, input bit w, input int v);
    if (w && o == KEY_OFS) begin
      sw = v == SELF_PROGRAM_SIGNATURE ? 5 : v == IO_UNLOCK_SIGNATURE ? sw : 0;
      iw = v == IO_UNLOCK_SIGNATURE ? 5 : 0;
    end else if (w) iw = 0;
    if (w) spb = 0;
    if (!w) rv = o == KEY_OFS ? (sw > 0) * 2 + (iw > 0) : o == SPL_OFS ? sp & 255 :
                 o == SPH_OFS ? th : o == FLAGS_OFS ? fl : 0;
    if (!w && o == SPL_OFS) th = sp >> 8;
    if (w && o == SPL_OFS) {tmp, spb} = {v, 32'd5};
    if (w && o == SPH_OFS) sp = (v << 8 | tmp) & SP_MASK;
    if (w && o == FLAGS_OFS) fl = (v & 'hEF) | ((v >> 2 ^ v >> 3) & 1) << 4;
    tick();
  endtask
  // status poll until idle, then compare the visible state
  task automatic sts;
    int n = 0;
    bit ie;
    do begin
      axr({28'h0, STAT_ADDR}, stat);
      tmo(n);
    end while (stat[ST_BUSY] !== 1'b0);
    chk("ioWin", stat[ST_IOWIN], iw > 0);
    chk("spmWin", stat[ST_SPMWIN], sw > 0);
    ie = fl[7] && iw + sw + spb == 0;
    tk += ie && pd;
    pd = pd && !ie;
    chk("irqEn", stat[ST_IRQEN], ie);
    chk("irqPend", {stat[ST_TAKEN +: 8], stat[ST_PEND]}, 16'(tk * 2 + pd));
    chk("tFlag", stat[ST_TFLAG], fl[6]);
  endtask
  task automatic cmd(input logic [5:0] o, input bit w, input bit wd, input logic [1:0] u,
                     input int v);
    int lo;
    axw({28'h0, CMD_ADDR}, {6'h00, u, wd, w, o, 16'(v)});
    chk("bresp", 16'(resp), 16'(RESP_OKAY));
    if (u == UNL_IO) acc(KEY_OFS, 1'b1, IO_UNLOCK_SIGNATURE);
    if (u == UNL_SPM) acc(KEY_OFS, 1'b1, SELF_PROGRAM_SIGNATURE);
    acc(o, w, v & 255);
    lo = rv;
    if (wd) acc(o + HIGH_STEP, w, (v >> 8) & 255);
    sts();
    if (!w) chk("rdata", wd ? stat[15:0] : 16'(stat[7:0]), 16'(wd ? rv * 256 + lo : lo));
  endtask
  task automatic evt(input int e);
    axw({28'h0, EVT_ADDR}, e);
    if (e[EVT_INSTR]) tick();
    if (e[EVT_DMEM]) iw = 0;
    if (e[EVT_NVM] || e[EVT_SLEEP]) {iw, sw} = 64'h0;
    if (e[EVT_IRQ]) pd = 1;
    if (e[EVT_SEI]) fl[7] = 1'b1;
    if (e[EVT_CLI]) fl[7] = 1'b0;
    if (e[EVT_BST]) fl[6] = e[EVT_BSTV];
    if (e[EVT_ALU]) fl = (fl & 'hC0) | e[13] << 5 | (e[11] ^ e[12]) << 4 | e[12:9];
    sts();
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    {awaddr, wdata, araddr, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    void'($urandom(32'h35adc891));
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    cmd(SPL_OFS, 1'b0, 1'b1, 2'h0, 0);
    cmd(KEY_OFS, 1'b0, 1'b0, 2'h0, 0);
    repeat (4) begin
      cmd(SPL_OFS, 1'b1, 1'b1, 2'h0, $urandom);
      cmd(SPL_OFS, 1'b0, 1'b1, 2'h0, 0);
      cmd(FLAGS_OFS, 1'b1, 1'b0, 2'h0, $urandom & 255);
      cmd(FLAGS_OFS, 1'b0, 1'b0, 2'h0, 0);
      evt(1 << EVT_ALU | ($urandom & 31) << EVT_AFL);
      cmd(FLAGS_OFS, 1'b0, 1'b0, 2'h0, 0);
    end
    evt(1 << EVT_SEI);
    for (int u = 1; u < 3; u++) begin
      cmd(KEY_OFS, 1'b0, 1'b0, 2'(u), 0);
      evt(1 << EVT_IRQ);
      repeat (3) evt(1 << EVT_INSTR);
      foreach (ev[i]) begin
        cmd(KEY_OFS, 1'b0, 1'b0, 2'(u), 0);
        evt(1 << ev[i]);
      end
      d = $urandom & 255;
      if (d == IO_UNLOCK_SIGNATURE || d == SELF_PROGRAM_SIGNATURE) d = 'h5A;
      cmd(KEY_OFS, 1'b1, 1'b0, 2'(u), d);
      cmd(KEY_OFS, 1'b0, 1'b0, 2'h0, 0);
    end
    evt(1 << EVT_CLI);
    cmd(FLAGS_OFS, 1'b1, 1'b0, 2'h0, 'h80);
    cmd(SPL_OFS, 1'b1, 1'b0, 2'h0, $urandom & 255);
    repeat (4) evt(1 << EVT_INSTR);
    evt(1 << EVT_BST | 1 << EVT_BSTV);
    evt(1 << EVT_BST);
    axw(32'hC, 32'h0);
    chk("unmappedResp", 16'(resp), 16'(RESP_SLVERR));
    axr(32'hC, stat);
    chk("unmappedData", stat[15:0], 16'h0000);
    complete_run();
  end
endmodule // cpu_config_change_protect_tb
